// file: core/tsicc_core.sv
// Connection control core of a sixteen-stream time slot interchange switch.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: After reset every stream offset is zero and the measured half flag reads one.
// R2: Stream offset selectable in half periods: whole bits plus latch edge half.
// R3: Measured delay gives whole periods; half period clears the flag, edge is inverse.
// R4: Loopback feeds an output stream channel byte back as same input stream channel.
// R5: Software keeps whole offset zero on streams using loopback.
// R6: Delay mode bit picks variable delay when low, constant delay when high.
// R7: Processor channel bit sends the word's own contents instead of switched data.
// R8: In processor channel mode only the low eight word bits are sent.
// R9: Otherwise the word is the data memory address of the source stream and channel.
// R10: Control channel bit leaves its pin one channel slot ahead of its channel.
// R11: Control channel bits go out stream zero first, then ascending streams.
// R12: Output enable set drives the slot normally; clear leaves the driver off.
// R13: Word bits ten to seven give the source stream number.
// R14: Software writes zero to word bits six and five.
// R15: Word bits four to zero give the source channel number.
// R16: Latch edge zero samples on rising clock edge, one on falling edge.
// R17: One sixteen-bit word per output channel, 512 words, read once per slot.
module tsicc_core
    import tsicc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [11:0] avAddress,
    input  wire logic        avRead,
    input  wire logic        avWrite,
    input  wire logic [31:0] avWritedata,
    input  wire logic [3:0]  avByteenable,
    output logic      [31:0] avReaddata,
    output logic             avWaitrequest,
    input  wire logic        bitClkPin,
    input  wire logic        framePinN,
    input  wire logic        frameEvalPinN,
    input  wire logic [15:0] rxPin,
    output logic      [15:0] txData,
    output logic      [15:0] txOe,
    output logic             controlChannelOut
);

    function automatic logic [15:0] mergeBe(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        mergeBe = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : mergeBe

    function automatic logic [3:0] firstSet(input logic [15:0] v);
        firstSet = 4'h0;
        for (int i = NSTR - 1; i >= 0; i--)
            if (v[i])
                firstSet = 4'(i);
    endfunction : firstSet

    logic [15:0] connMem  [512];
    logic [7:0]  dataMem  [1024];
    logic        lastBank [512];

    logic [1:0]  bclkS, frmS, feS;
    logic [15:0] rxS1, rxS2;
    logic        bclkPrevQ, fePrevQ;

    logic [8:0]  halfQ, halfD;
    logic        bankQ, bankD, edgeQ, edgeD, bndQ, bndD;

    logic [3:0]  ofsQ [NSTR];
    logic [3:0]  ofsD [NSTR];

    logic [7:0]  rxShQ [NSTR];
    logic [7:0]  rxShD [NSTR];
    logic [7:0]  rxByteQ [NSTR];
    logic [7:0]  rxByteD [NSTR];
    logic [4:0]  rxChQ [NSTR];
    logic [4:0]  rxChD [NSTR];
    logic [15:0] pendQ, pendD, pendSet, pendClr;
    logic [3:0]  pick;

    logic [16:0] fifoQ [FIFO_DEPTH];
    logic [16:0] fifoD [FIFO_DEPTH];
    logic        wpQ, wpD, rpQ, rpD, push, pop, pushRdy;
    logic [1:0]  cntQ, cntD;

    logic [4:0]  loadCntQ, loadCntD, loadCh;
    logic [15:0] word;
    logic [8:0]  src;
    logic        rdBank;
    logic [7:0]  loadByte;
    logic [7:0]  txAQ [NSTR];
    logic [7:0]  txAD [NSTR];
    logic [7:0]  txBQ [NSTR];
    logic [7:0]  txBD [NSTR];
    logic [7:0]  txShQ [NSTR];
    logic [7:0]  txShD [NSTR];
    logic [7:0]  txCurQ [NSTR];
    logic [7:0]  txCurD [NSTR];
    logic [15:0] oeAQ, oeAD, oeBQ, oeBD, ccoAQ, ccoAD, ccoBQ, ccoBD;
    logic [15:0] lpAQ, lpAD, lpBQ, lpBD, lpCurQ, lpCurD, txOeQ, txOeD;
    logic        ccoQ, ccoD;

    tsicc_meas_t measQ, measD;
    logic [2:0]  measWholeQ, measWholeD;
    logic        measFlagQ, measFlagD, measDoneQ, measDoneD, measStart, feFall;

    logic        waitQ, waitD, busWr, cmHit, ofsHit;
    logic [31:0] rdQ, rdD;

    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bclkS     <= 2'h0;
            frmS      <= 2'h3;
            feS       <= 2'h3;
            rxS1      <= 16'h0000;
            rxS2      <= 16'h0000;
            bclkPrevQ <= 1'b0;
            fePrevQ   <= 1'b1;
        end
        else
        begin
            bclkS     <= {bclkS[0], bitClkPin};
            frmS      <= {frmS[0], framePinN};
            feS       <= {feS[0], frameEvalPinN};
            rxS1      <= rxPin;
            rxS2      <= rxS1;
            bclkPrevQ <= bclkS[1];
            fePrevQ   <= feS[1];
        end
    end

    // Half-period position in the frame; the frame pulse is taken at a falling edge.
    always_comb
    begin
        edgeD = bclkS[1] ^ bclkPrevQ;
        halfD = halfQ;
        bankD = bankQ;
        bndD  = 1'b0;
        if (edgeD)
        begin
            if (bclkPrevQ && !frmS[1])
            begin
                halfD = HALF_RESET;
                bankD = ~bankQ;
            end
            else
                halfD = halfQ + 9'h001;
            bndD = (halfD[3:0] == 4'h0);
        end
    end

    // Offset fields, four streams per register, written per byte lane.
    always_comb
    begin
        ofsD = ofsQ;
        if (busWr && ofsHit)
            for (int k = 0; k < 4; k++)
                if (avByteenable[k/2])
                    ofsD[{avAddress[3:2], 2'(k)}] = avWritedata[4*k +: 4]; // [R2]
    end

    // Input sampling per stream, shifted by its offset in half periods.
    always_comb
    begin
        logic [8:0] loc;
        loc     = HALF_RESET;
        rxShD   = rxShQ;
        rxByteD = rxByteQ;
        rxChD   = rxChQ;
        pendSet = 16'h0000;
        for (int s = 0; s < NSTR; s++)
        begin
            loc = halfQ - {5'h00, ofsQ[s]}; // [R2]
            if (edgeQ && loc[0]) // [R16]
            begin
                rxShD[s] = {rxShQ[s][6:0], rxS2[s]};
                if (loc[3:1] == LAST_BIT)
                begin
                    rxByteD[s] = lpCurQ[s] ? txCurQ[s] : rxShD[s]; // [R4] [R5]
                    rxChD[s]   = loc[8:4];
                    pendSet[s] = 1'b1;
                end
            end
        end
        pick    = firstSet(pendQ);
        pushRdy = (cntQ != 2'(FIFO_DEPTH));
        push    = (pendQ != 16'h0000) && pushRdy;
        pendClr = push ? (16'h0001 << pick) : 16'h0000;
        pendD   = (pendQ & ~pendClr) | pendSet;
    end

    // Two-entry buffer into the data memory; drains only while the loader is idle.
    always_comb
    begin
        pop  = (cntQ != 2'h0) && loadCntQ[4];
        fifoD = fifoQ;
        if (push)
            fifoD[wpQ] = {pick, rxChQ[pick], rxByteQ[pick]};
        wpD  = wpQ ^ push;
        rpD  = rpQ ^ pop;
        cntD = cntQ + {1'b0, push} - {1'b0, pop};
    end

    // Loads the words for two channels ahead, one stream per cycle.
    always_comb
    begin
        loadCh   = halfQ[8:4] + LOAD_AHEAD;
        word     = connMem[{loadCntQ[3:0], loadCh}]; // [R17]
        src      = {word[SSTR_HI:SSTR_LO], word[SCH_HI:SCH_LO]}; // [R9] [R13] [R15] [R14]
        rdBank   = word[DMODE_BIT] ? ~bankQ : lastBank[src]; // [R6]
        loadByte = word[PROC_BIT] ? word[PROC_HI:0] : dataMem[{rdBank, src}]; // [R7] [R8]
        loadCntD = loadCntQ;
        txAD = txAQ;
        txBD = txBQ;
        txShD = txShQ;
        txCurD = txCurQ;
        oeAD = oeAQ;
        oeBD = oeBQ;
        ccoAD = ccoAQ;
        ccoBD = ccoBQ;
        lpAD = lpAQ;
        lpBD = lpBQ;
        lpCurD = lpCurQ;
        txOeD = txOeQ;
        if (bndQ)
        begin
            loadCntD = 5'h00;
            txShD  = txBQ;
            txCurD = txBQ;
            txOeD  = oeBQ; // [R12]
            lpCurD = lpBQ;
            txBD   = txAQ;
            oeBD   = oeAQ;
            ccoBD  = ccoAQ;
            lpBD   = lpAQ;
        end
        else
        begin
            if (!loadCntQ[4])
            begin
                loadCntD = loadCntQ + 5'h01;
                txAD[loadCntQ[3:0]]  = loadByte;
                oeAD[loadCntQ[3:0]]  = word[OE_BIT];
                ccoAD[loadCntQ[3:0]] = word[CCO_BIT];
                lpAD[loadCntQ[3:0]]  = word[CHANNEL_LOOPBACK_BIT];
            end
            if (edgeQ && !halfQ[0])
                for (int s = 0; s < NSTR; s++)
                    txShD[s] = {txShQ[s][6:0], 1'b0};
        end
        ccoD = bndQ ? ccoAQ[0] : ccoBQ[halfQ[3:0]]; // [R10] [R11]
    end

    // Frame delay measurement against the frame evaluation input.
    always_comb
    begin
        feFall     = fePrevQ && !feS[1];
        measD      = measQ;
        measWholeD = measWholeQ;
        measFlagD  = measFlagQ;
        measDoneD  = measDoneQ;
        case (measQ)
            MEAS_IDLE:
                if (measStart)
                begin
                    measD     = MEAS_WAIT;
                    measDoneD = 1'b0;
                end
            MEAS_WAIT:
                if (edgeQ && halfQ == HALF_RESET)
                    measD = MEAS_ARMED;
            MEAS_ARMED:
                if (feFall)
                begin
                    measWholeD = halfQ[3:1]; // [R3]
                    measFlagD  = ~halfQ[0]; // [R3]
                    measDoneD  = 1'b1;
                    measD      = MEAS_IDLE;
                end
            default:
                measD = MEAS_IDLE;
        endcase
    end

    // Avalon-MM slave: one wait cycle, then the access completes.
    always_comb
    begin
        cmHit     = (avAddress <= CM_LAST);
        ofsHit    = (avAddress >= OFS_BASE) && (avAddress <= OFS_LAST);
        busWr     = avWrite && !waitQ;
        measStart = busWr && (avAddress == MEAS_CTRL) && avByteenable[0] && avWritedata[0];
        waitD     = 1'b1;
        rdD       = rdQ;
        if ((avRead || avWrite) && waitQ)
        begin
            waitD = 1'b0;
            rdD   = 32'h00000000;
            if (cmHit)
                rdD[15:0] = connMem[avAddress[10:2]];
            else if (ofsHit)
                for (int k = 0; k < 4; k++)
                    rdD[4*k +: 4] = ofsQ[{avAddress[3:2], 2'(k)}];
            else if (avAddress == MEAS_CTRL)
                rdD[0] = (measQ != MEAS_IDLE);
            else if (avAddress == MEAS_RES)
                rdD[MRES_DONE_BIT:0] = {measDoneQ, measFlagQ, measWholeQ};
        end
    end

    // Memories: bus writes to connection words, buffer drain into data memory.
    always_ff @(posedge clk)
    begin
        if (busWr && cmHit)
            connMem[avAddress[10:2]] <= mergeBe(connMem[avAddress[10:2]], avWritedata[15:0],
                                                avByteenable[1:0]);
        if (pop)
        begin
            dataMem[{bankQ, fifoQ[rpQ][16:8]}] <= fifoQ[rpQ][7:0];
            lastBank[fifoQ[rpQ][16:8]]        <= bankQ; // [R6]
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            halfQ <= HALF_RESET;
            bankQ <= 1'b0;
            edgeQ <= 1'b0;
            bndQ  <= 1'b0;
            for (int s = 0; s < NSTR; s++)
            begin
                ofsQ[s]    <= OFS_RESET; // [R1]
                rxShQ[s]   <= 8'h00;
                rxByteQ[s] <= 8'h00;
                rxChQ[s]   <= 5'h00;
                txAQ[s]    <= 8'h00;
                txBQ[s]    <= 8'h00;
                txShQ[s]   <= 8'h00;
                txCurQ[s]  <= 8'h00;
            end
            for (int i = 0; i < FIFO_DEPTH; i++)
                fifoQ[i] <= 17'h00000;
            pendQ <= 16'h0000;
            wpQ <= 1'b0;
            rpQ <= 1'b0;
            cntQ <= 2'h0;
            loadCntQ <= LOAD_IDLE;
            {oeAQ, oeBQ, ccoAQ, ccoBQ} <= 64'h0;
            {lpAQ, lpBQ, lpCurQ, txOeQ} <= 64'h0;
            ccoQ <= 1'b0;
            measQ <= MEAS_IDLE;
            measWholeQ <= MEAS_WHOLE_RESET; // [R1]
            measFlagQ <= MEAS_FLAG_RESET; // [R1]
            measDoneQ <= 1'b0;
            waitQ <= 1'b1;
            rdQ <= 32'h00000000;
        end
        else
        begin
            halfQ <= halfD;
            bankQ <= bankD;
            edgeQ <= edgeD;
            bndQ  <= bndD;
            ofsQ  <= ofsD;
            rxShQ <= rxShD;
            rxByteQ <= rxByteD;
            rxChQ <= rxChD;
            pendQ <= pendD;
            fifoQ <= fifoD;
            wpQ <= wpD;
            rpQ <= rpD;
            cntQ <= cntD;
            loadCntQ <= loadCntD;
            txAQ <= txAD;
            txBQ <= txBD;
            txShQ <= txShD;
            txCurQ <= txCurD;
            {oeAQ, oeBQ, ccoAQ, ccoBQ} <= {oeAD, oeBD, ccoAD, ccoBD};
            {lpAQ, lpBQ, lpCurQ, txOeQ} <= {lpAD, lpBD, lpCurD, txOeD};
            ccoQ <= ccoD;
            measQ <= measD;
            measWholeQ <= measWholeD;
            measFlagQ <= measFlagD;
            measDoneQ <= measDoneD;
            waitQ <= waitD;
            rdQ <= rdD;
        end
    end

    always_comb
    begin
        for (int s = 0; s < NSTR; s++)
            txData[s] = txShQ[s][7];
    end

    assign txOe              = txOeQ;
    assign controlChannelOut = ccoQ;
    assign avReaddata        = rdQ;
    assign avWaitrequest     = waitQ;

endmodule : tsicc_core
`default_nettype wire

// file: pkg/tsicc_pkg.sv
// Constants and types shared by the connection control core.
package tsicc_pkg;

    localparam int NSTR = 16;
    localparam int NCH  = 32;

    // Register byte addresses on the Avalon-MM slave.
    localparam logic [11:0] CM_LAST   = 12'h7fc;
    localparam logic [11:0] OFS_BASE  = 12'h800;
    localparam logic [11:0] OFS_LAST  = 12'h80c;
    localparam logic [11:0] MEAS_CTRL = 12'h810;
    localparam logic [11:0] MEAS_RES  = 12'h814;

    // Connection memory word fields.
    localparam int CHANNEL_LOOPBACK_BIT   = 15;
    localparam int DMODE_BIT  = 14;
    localparam int PROC_BIT   = 13;
    localparam int CCO_BIT    = 12;
    localparam int OE_BIT     = 11;
    localparam int SSTR_HI    = 10;
    localparam int SSTR_LO    = 7;
    localparam int SCH_HI     = 4;
    localparam int SCH_LO     = 0;
    localparam int PROC_HI    = 7;

    // Per-stream offset nibble: latch edge in bit 0, whole periods in bits 3..1.
    localparam int OFS_EDGE_BIT = 0;
    localparam int OFS_WHOLE_HI = 3;
    localparam int OFS_WHOLE_LO = 1;

    // Measurement result fields.
    localparam int MRES_DONE_BIT = 4;
    localparam int MRES_FLAG_BIT = 3;

    // Values after reset.
    localparam logic [3:0] OFS_RESET        = 4'h0;
    localparam logic [2:0] MEAS_WHOLE_RESET = 3'h0;
    localparam logic       MEAS_FLAG_RESET  = 1'b1;
    localparam logic [4:0] LOAD_IDLE        = 5'h10;
    localparam logic [8:0] HALF_RESET       = 9'h000;

    // Frame constants: load lead in channels, last bit index, buffer depth in entries.
    localparam logic [4:0] LOAD_AHEAD = 5'h02;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam int         FIFO_DEPTH = 2;

    typedef enum logic [1:0] {
        MEAS_IDLE  = 2'b00,
        MEAS_WAIT  = 2'b01,
        MEAS_ARMED = 2'b11
    } tsicc_meas_t;

endpackage : tsicc_pkg

// file: verification/testbench.sv
// Self-checking testbench for the connection control core.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import tsicc_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] avAddress = 12'h000;
    logic        avRead = 1'b0;
    logic        avWrite = 1'b0;
    logic [31:0] avWritedata = 32'h0;
    logic [3:0]  avByteenable = 4'hf;
    logic [8:0]  evalHalf = 9'h007;
    logic [31:0] avReaddata;
    logic        avWaitrequest;
    logic        bitClkPin;
    logic        framePinN;
    logic        frameEvalPinN;
    logic [15:0] rxPin;
    logic [15:0] txData;
    logic [15:0] txOe;
    logic        controlChannelOut;
    wire         txPin0;
    int          err_count = 0;
    int          checked = 0;
    logic [31:0] rd;
    logic [15:0] bits;
    assign txPin0 = txOe[0] ? txData[0] : 1'bz;
    initial
    begin
        forever #10 clk = ~clk;
    end
    tsicc_core tsicc_core_i (.clk, .srst, .avAddress, .avRead, .avWrite, .avWritedata,
        .avByteenable, .avReaddata, .avWaitrequest, .bitClkPin, .framePinN,
        .frameEvalPinN, .rxPin, .txData, .txOe, .controlChannelOut);
    tsicc_stream_model tsicc_stream_model_i (.clk, .evalHalf, .bitClkPin, .framePinN,
        .frameEvalPinN, .rxPin);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Mismatches %0d, checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        avAddress <= a;
        avWritedata <= d;
        avWrite <= wr;
        avRead <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avWaitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            err_count++;
        rd = avReaddata;
        avWrite <= 1'b0;
        avRead <= 1'b0;
        @(posedge clk);
    endtask : access
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdChk
    task automatic waitOe(input int s, input logic v);
        int n = 0;
        while (txOe[s] !== v && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000)
            err_count++;
    endtask : waitOe
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 4; r++)
            rdChk(OFS_BASE + 12'(4 * r), 32'h0);
        rdChk(MEAS_RES, 32'h8);
        for (int r = 0; r < 4; r++)
        begin
            for (int k = 0; k < 4; k++)
                bits[4*k +: 4] = 4'((4 * r + k) % 10);
            access(1'b1, OFS_BASE + 12'(4 * r), {16'h0, bits});
            rdChk(OFS_BASE + 12'(4 * r), {16'h0, bits});
        end
        for (int w = 0; w < 512; w++)
            access(1'b1, 12'(4 * w), (w < 32 && w % 2 == 0) ? 32'h38a5 :
                   (w == 36) ? 32'h0d05 : 32'h0);
        access(1'b1, CM_LAST, 32'hffffc79f);
        rdChk(CM_LAST, 32'hc79f);
        rdChk(12'h000, 32'h38a5);
        access(1'b1, 12'h818, 32'hffff);
        rdChk(12'h818, 32'h0);
        repeat (4200) @(posedge clk);
        waitOe(0, 1'b0);
        waitOe(0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge bitClkPin);
            bits = {bits[14:0], txPin0};
        end
        check({24'h0, bits[7:0]}, 32'ha5);
        check({16'h0, txOe}, 32'h1);
        waitOe(0, 1'b0);
        repeat (2) @(posedge clk);
        bits[0] = controlChannelOut;
        for (int k = 1; k < 16; k++)
        begin
            @(bitClkPin);
            repeat (6) @(posedge clk);
            bits[k] = controlChannelOut;
        end
        check({16'h0, bits}, 32'h1);
        waitOe(1, 1'b0);
        waitOe(1, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge bitClkPin);
            bits = {bits[14:0], txData[1]};
        end
        check({24'h0, bits[7:0]}, 32'h55);
        for (int m = 0; m < 2; m++)
        begin
            evalHalf <= 9'(7 - m);
            access(1'b1, MEAS_CTRL, 32'h1);
            rd = 32'h0;
            for (int n = 0; n < 5000 && rd[MRES_DONE_BIT] !== 1'b1; n++)
                access(1'b0, MEAS_RES, 32'h0);
            check(rd, m ? 32'h1b : 32'h13);
        end
        test_done();
    end
endmodule : testbench
`default_nettype wire

// file: verification/tsicc_core_props.sv
// Port checker for the connection control core.
`timescale 1ns/100ps
`default_nettype none
module tsicc_core_props
    import tsicc_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [11:0] avAddress,
    input wire logic        avRead,
    input wire logic        avWrite,
    input wire logic [31:0] avReaddata,
    input wire logic        avWaitrequest,
    input wire logic [15:0] txData,
    input wire logic [15:0] txOe,
    input wire logic        controlChannelOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence sTaken;
        (avRead || avWrite) && avWaitrequest;
    endsequence
    sequence sAnswer;
        !avWaitrequest ##1 avWaitrequest;
    endsequence
    AST_ANSWER: assert property (sTaken |=> sAnswer)
        else $error("Access not answered after one wait cycle.");
    AST_IDLE: assert property (!avRead && !avWrite && avWaitrequest |=> avWaitrequest)
        else $error("Wait request dropped without a request.");
    AST_RESET: assert property ($fell(srst) |-> avWaitrequest && txOe == 16'h0000
        && txData == 16'h0000 && !controlChannelOut && avReaddata == 32'h0)
        else $error("Outputs not at rest after reset.");
    AST_RDATA: assert property (avWaitrequest && $past(avWaitrequest) |-> $stable(avReaddata))
        else $error("Read data moved between accesses.");
    AST_UNMAPPED: assert property (avRead && avWaitrequest && avAddress[11:2] > MEAS_RES[11:2]
        |=> avReaddata == 32'h0)
        else $error("Unmapped read returned nonzero.");
    AST_OE_SLOT: assert property ($changed(txOe) |=> $stable(txOe) [*8])
        else $error("Output enable changed inside a slot.");
    AST_TX_BIT: assert property ($changed(txData) |=> $stable(txData) [*8])
        else $error("Serial bit shorter than a bit period.");
    AST_CCO_HALF: assert property ($changed(controlChannelOut)
        |=> $stable(controlChannelOut) [*4])
        else $error("Control channel bit shorter than a half period.");
endmodule : tsicc_core_props
bind tsicc_core tsicc_core_props tsicc_core_props_i (.clk, .srst, .avAddress, .avRead,
    .avWrite, .avReaddata, .avWaitrequest, .txData, .txOe, .controlChannelOut);
`default_nettype wire

// file: verification/tsicc_stream_model.sv
// Serial side model: bit clock, frame pulse, evaluation pulse and input streams.
`timescale 1ns/100ps
`default_nettype none
module tsicc_stream_model
(
    input  wire logic       clk,
    input  wire logic [8:0] evalHalf,
    output logic            bitClkPin,
    output logic            framePinN,
    output logic            frameEvalPinN,
    output logic [15:0]     rxPin
);
    logic [2:0] sub_q = 3'h0;
    logic [8:0] half_q = 9'h000;
    always @(posedge clk)
    begin
        sub_q <= sub_q + 3'h1;
        if (sub_q == 3'h7)
            half_q <= half_q + 9'h001;
    end
    // Bit clock falls at each bit cell start; frame pulse straddles the half zero edge.
    assign bitClkPin = half_q[0];
    assign framePinN = !((half_q == 9'h1ff && sub_q[2]) || (half_q == 9'h000 && !sub_q[2]));
    assign frameEvalPinN = !((half_q == evalHalf && sub_q[2]) || half_q == evalHalf + 9'h001);
    assign rxPin = {16{half_q[1]}} ^ 16'h5a5a;
endmodule : tsicc_stream_model
`default_nettype wire
